// ---- rtl/sensor_status_regs.vh ----
/*
 * Constants of the sensor status word, its commands and the CRC-8 check.
 * Assumes inclusion by bare name from the design and bench files.
 */
`ifndef SENSOR_STATUS_REGS_VH
`define SENSOR_STATUS_REGS_VH

// =============================================================
// status word bit positions
`define BIT_ALERT_PEND 15
`define BIT_TRACK_ALERT 10
`define BIT_RESET_SEEN 4
`define BIT_CMD_FAIL 1
`define BIT_WR_CRC_FAIL 0

// =============================================================
// reset values of the status flags
`define RST_ALERT_PEND 1'h1
`define RST_TRACK_ALERT 1'h0
`define RST_RESET_SEEN 1'h1
`define RST_CMD_FAIL 1'h0
`define RST_WR_CRC_FAIL 1'h0

// =============================================================
// command codes
`define CMD_CLEAR_STATUS 16'h3041
`define CMD_SOFT_RESET 16'h30A2
`define CMD_READ_STATUS 16'hF300
`define CMD_FETCH_TEMP 16'hE000

// =============================================================
// CRC-8 properties
`define CRC_POLY 8'h31
`define CRC_INIT 8'hFF
`define CRC_XOROUT 8'h00

// =============================================================
// transfer layout
`define BYTE_BITS 4'h8
`define RX_CMD_BYTES 3'h2
`define RX_FULL_BYTES 3'h5
`define TX_IDX_HI 2'h0
`define TX_IDX_LO 2'h1
`define TX_IDX_CRC 2'h2
`define TX_FILL 8'hFF
`define DEV_ADDR_DEFAULT 7'h44

`endif

// ---- rtl/line_sync.v ----
/*
 * Synchroniser and condition finder for the serial clock and data pins.
 * Assumes both pins are asynchronous to clk; a level is accepted once the
 * second and third flops agree.
 */
`timescale 1ns/1ps

module line_sync
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // raw pin levels
    input wire sclPin,
    input wire sdaPin,
    // filtered levels and one-cycle conditions
    output reg sdaLevel,
    output reg sclRise,
    output reg sclFall,
    output reg busStart,
    output reg busStop
);

reg [2:0] sclSync;
reg [2:0] sdaSync;
reg sclLevel;
reg next_scl;
reg next_sda;

// =============================================================
// accept a level only when stages two and three agree
always @*
begin
    next_scl = (sclSync[1] == sclSync[2]) ? sclSync[2] : sclLevel;
    next_sda = (sdaSync[1] == sdaSync[2]) ? sdaSync[2] : sdaLevel;
end

// =============================================================
// three-flop chains; the idle bus is high on both lines
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        sclSync <= 3'h7;
        sdaSync <= 3'h7;
        sclLevel <= 1'h1;
        sdaLevel <= 1'h1;
        sclRise <= 1'h0;
        sclFall <= 1'h0;
        busStart <= 1'h0;
        busStop <= 1'h0;
    end
    else
    begin
        sclSync <= {sclSync[1:0], sclPin};
        sdaSync <= {sdaSync[1:0], sdaPin};
        sclLevel <= next_scl;
        sdaLevel <= next_sda;
        sclRise <= next_scl & ~sclLevel;
        sclFall <= ~next_scl & sclLevel;
        // data moving while clock stays high marks start or stop
        busStart <= sclLevel & next_scl & sdaLevel & ~next_sda;
        busStop <= sclLevel & next_scl & ~sdaLevel & next_sda;
    end
end

endmodule // line_sync

// ---- rtl/sensor_status_crc.v ----
/*
 * Serial-bus slave holding the sensor status word and the CRC-8 check.
 * Assumes the measurement core supplies the raw code, alert and supply
 * events on clk, and an idle flag gating soft reset.
 */
// How it works
// - clear command zeroes bits 15, 10, 4
// - bit15 alert pending, bit10 tracking alert
// - bit4 set by any reset, sticky
// - bit1 flags invalid or failed command
// - bit0 flags bad write data CRC
// - CRC-8 poly 31, init FF, no reflection
// - CRC after each word, restarted per word
// - CRC appended on reads, checked on writes
// - temperature word is raw unsigned code
// - soft reset only when idle, marks reset
`timescale 1ns/1ps
`include "sensor_status_regs.vh"

module sensor_status_crc
#(
    parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
)
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // serial bus pins, open drain
    input wire sclIn,
    input wire sdaIn,
    output wire sdaOut,
    output reg sdaOe,
    // measurement core side
    input wire [15:0] raw_temperature_code,
    input wire trackAlertEvent,
    input wire supplyFailEvent,
    input wire sysIdle,
    output reg softResetReq,
    output reg [15:0] statusWord
);

localparam S_IDLE = 3'h0;
localparam S_ADDR = 3'h1;
localparam S_WACK = 3'h2;
localparam S_RX = 3'h3;
localparam S_TX = 3'h4;
localparam S_RACK = 3'h5;

reg [2:0] state;
reg [3:0] bitCnt;
reg [1:0] txIdx;
reg [2:0] rxCnt;
reg [15:0] txWord, cmdWord, dataWord;
reg [7:0] shiftIn, txShift, dataCrc, txByte;
reg readDir, hostAck, readTemp, alertPend, trackAlert, resetSeen;
reg cmdFail, wrCrcFail, cmdOk, doClear, doSoft;
wire sdaLevel, sclRise, sclFall, busStart, busStop, execNow, lenOk;
wire [2:0] next_rxCnt;

// bitwise CRC over one 16-bit word, generator restarted each call
function [7:0] crc8;
    input [15:0] word;
    integer i;
    reg [7:0] c;
    begin
        c = `CRC_INIT;
        for (i = 15; i >= 0; i = i - 1)
        begin
            if (c[7] ^ word[i])
                c = {c[6:0], 1'b0} ^ `CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        crc8 = c ^ `CRC_XOROUT;
    end
endfunction

// =============================================================
// pin conditioning
line_sync u_sync
(
    .clk(clk),
    .nrst(nrst),
    .sclPin(sclIn),
    .sdaPin(sdaIn),
    .sdaLevel(sdaLevel),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .busStart(busStart),
    .busStop(busStop)
);

// open drain: the pin is only ever pulled low
assign sdaOut = 1'b0;

// a write phase is executed when stop or repeated start closes it
assign execNow = (busStart | busStop) & (rxCnt != 3'h0);
assign next_rxCnt = (rxCnt == `RX_FULL_BYTES) ? rxCnt : rxCnt + 3'h1;
// a bare command or a command with one protected word is legal; bytes after the fifth are ignored
assign lenOk = (rxCnt == `RX_CMD_BYTES) | (rxCnt == `RX_FULL_BYTES);

// =============================================================
// command decode at the end of a write phase
always @*
begin
    case (cmdWord)
        `CMD_CLEAR_STATUS: cmdOk = lenOk;
        `CMD_SOFT_RESET: cmdOk = lenOk & sysIdle;
        `CMD_READ_STATUS: cmdOk = lenOk;
        `CMD_FETCH_TEMP: cmdOk = lenOk;
        default: cmdOk = 1'b0;
    endcase
    doClear = cmdOk & (cmdWord == `CMD_CLEAR_STATUS);
    doSoft = cmdOk & (cmdWord == `CMD_SOFT_RESET);
end

// =============================================================
// byte to put on the bus: word high, word low, then its CRC
always @*
begin
    case (txIdx)
        `TX_IDX_HI: txByte = txWord[15:8];
        `TX_IDX_LO: txByte = txWord[7:0];
        `TX_IDX_CRC: txByte = crc8(txWord);
        default: txByte = `TX_FILL;
    endcase
end

// =============================================================
// bus protocol engine, stepped on filtered clock edges
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        state <= S_IDLE;
        bitCnt <= 4'h0;
        shiftIn <= 8'h00;
        txShift <= 8'h00;
        txIdx <= 2'h0;
        txWord <= 16'h0000;
        readDir <= 1'b0;
        hostAck <= 1'b0;
        rxCnt <= 3'h0;
        cmdWord <= 16'h0000;
        dataWord <= 16'h0000;
        dataCrc <= 8'h00;
        sdaOe <= 1'b0;
    end
    else if (busStart | busStop)
    begin
        // conditions override any byte in flight
        state <= busStart ? S_ADDR : S_IDLE;
        bitCnt <= 4'h0;
        rxCnt <= 3'h0;
        sdaOe <= 1'b0;
    end
    else if (sclRise)
    begin
        if (state == S_ADDR || state == S_RX)
        begin
            shiftIn <= {shiftIn[6:0], sdaLevel};
            bitCnt <= bitCnt + 4'h1;
        end
        else if (state == S_RACK)
            hostAck <= ~sdaLevel;
    end
    else if (sclFall)
    begin
        case (state)
            S_ADDR:
            begin
                if (bitCnt == `BYTE_BITS)
                begin
                    if (shiftIn[7:1] == DEV_ADDR)
                    begin
                        state <= S_WACK;
                        sdaOe <= 1'b1;
                        readDir <= shiftIn[0];
                        // a read returns the word picked by the last accepted command
                        txWord <= readTemp ? raw_temperature_code
                                           : statusWord;
                        txIdx <= `TX_IDX_HI;
                    end
                    else
                        state <= S_IDLE;
                end
            end
            S_RX:
            begin
                if (bitCnt == `BYTE_BITS)
                begin
                    state <= S_WACK;
                    sdaOe <= 1'b1;
                    rxCnt <= next_rxCnt;
                    case (rxCnt)
                        3'h0: cmdWord[15:8] <= shiftIn;
                        3'h1: cmdWord[7:0] <= shiftIn;
                        3'h2: dataWord[15:8] <= shiftIn;
                        3'h3: dataWord[7:0] <= shiftIn;
                        3'h4: dataCrc <= shiftIn;
                        default: dataCrc <= dataCrc;
                    endcase
                end
            end
            S_WACK:
            begin
                // a read goes on with its first bit, a write releases
                state <= readDir ? S_TX : S_RX;
                sdaOe <= readDir & ~txByte[7];
                txShift <= {txByte[6:0], 1'b1};
                bitCnt <= readDir ? 4'h1 : 4'h0;
            end
            S_TX:
            begin
                if (bitCnt == `BYTE_BITS)
                begin
                    state <= S_RACK;
                    sdaOe <= 1'b0;
                    txIdx <= (txIdx == 2'h3) ? txIdx : txIdx + 2'h1;
                end
                else
                begin
                    sdaOe <= ~txShift[7];
                    txShift <= {txShift[6:0], 1'b1};
                    bitCnt <= bitCnt + 4'h1;
                end
            end
            S_RACK:
            begin
                // a not-acknowledge ends the read; wait for stop
                state <= hostAck ? S_TX : S_IDLE;
                sdaOe <= hostAck & ~txByte[7];
                txShift <= {txByte[6:0], 1'b1};
                bitCnt <= 4'h1;
            end
            default: state <= S_IDLE;
        endcase
    end
end

// =============================================================
// sticky flags: a setting event in the clearing cycle wins
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        alertPend <= `RST_ALERT_PEND;
        trackAlert <= `RST_TRACK_ALERT;
        resetSeen <= `RST_RESET_SEEN;
        cmdFail <= `RST_CMD_FAIL;
        wrCrcFail <= `RST_WR_CRC_FAIL;
        readTemp <= 1'b0;
        softResetReq <= 1'b0;
    end
    else
    begin
        softResetReq <= execNow & doSoft;
        alertPend <= trackAlertEvent
            | (alertPend & ~(execNow & doClear));
        trackAlert <= trackAlertEvent | (trackAlert & ~(execNow & doClear));
        resetSeen <= supplyFailEvent | (execNow & doSoft)
            | (resetSeen & ~(execNow & doClear));
        if (execNow)
        begin
            cmdFail <= ~cmdOk;
            // only a write carrying a protected word updates bit 0
            if (rxCnt == `RX_FULL_BYTES)
                wrCrcFail <= (crc8(dataWord) != dataCrc);
            if (cmdOk)
                readTemp <= (cmdWord == `CMD_FETCH_TEMP);
        end
    end
end

// =============================================================
// visible status word; reserved positions held at zero
always @*
begin
    statusWord = 16'h0000;
    statusWord[`BIT_ALERT_PEND] = alertPend;
    statusWord[`BIT_TRACK_ALERT] = trackAlert;
    statusWord[`BIT_RESET_SEEN] = resetSeen;
    statusWord[`BIT_CMD_FAIL] = cmdFail;
    statusWord[`BIT_WR_CRC_FAIL] = wrCrcFail;
end

endmodule // sensor_status_crc

// ---- tb/host_master.sv ----
/*
 * Serial-bus host model: start, stop and byte transfers at a 160 ns SCL.
 * Assumes an open-drain data line with a pull-up, and SCL standing high
 * between frames.
 */
`timescale 1ns/1ps

module host_master
(
    // clock
    input wire clk,
    // bus lines
    input wire sdaOe,
    output reg scl,
    output wire sda
);
    reg sdaLow;

    // =====================================================
    // wire level
    // pull-up: released line reads high, anyone may pull it low
    assign sda = !(sdaLow | sdaOe);
    initial
    begin
        scl = 1'h1;
        sdaLow = 1'h0;
    end

    // =====================================================
    // bus tasks, every change just after a clk edge
    task w(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task start;
        sdaLow <= 1'h1;
        w(8);
        scl <= 1'h0;
        w(4);
    endtask
    task stop;
        sdaLow <= 1'h1;
        w(4);
        scl <= 1'h1;
        w(8);
        sdaLow <= 1'h0;
        w(8);
    endtask
    // data set mid-low, sampled mid-high
    task bitw(input b, output r);
        sdaLow <= !b;
        w(4);
        scl <= 1'h1;
        w(4);
        r = sda;
        w(4);
        scl <= 1'h0;
        w(4);
    endtask
    // eight bits msb first, then the acknowledge bit
    task xfer(input [7:0] d, input ab, output [7:0] q, output a);
        integer i;
        reg r;
        for (i = 7; i >= 0; i--)
        begin
            bitw(d[i], r);
            q[i] = r;
        end
        bitw(ab, a);
    endtask
endmodule // host_master

// ---- tb/sensor_status_chk.sv ----
/*
 * Checker of the status word and bus drive of the status block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module sensor_status_chk
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // ports watched
    input wire sclIn,
    input wire sdaOut,
    input wire sdaOe,
    input wire trackAlertEvent,
    input wire supplyFailEvent,
    input wire sysIdle,
    input wire softResetReq,
    input wire [15:0] statusWord
);
    // =====================================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_reserved_zero: assert property (
        statusWord[14:11] == 4'h0 && statusWord[3:2] == 2'h0)
        else $error("reserved status bits not zero");
    chk_alert_sets: assert property (
        trackAlertEvent |=> statusWord[15] && statusWord[10])
        else $error("alert event did not set bits 15 and 10");
    chk_alert_cause: assert property (
        $rose(statusWord[10]) |-> $past(trackAlertEvent))
        else $error("tracking alert set without event");
    chk_supply_sets: assert property (
        supplyFailEvent |=> statusWord[4])
        else $error("supply failure did not set bit 4");
    chk_clear_group: assert property (
        $fell(statusWord[4]) |-> !statusWord[10] || $past(trackAlertEvent))
        else $error("reset flag cleared alone");
    chk_pulse_single: assert property (
        softResetReq |=> !softResetReq)
        else $error("soft reset pulse too long");
    chk_soft_idle: assert property (
        softResetReq |-> $past(sysIdle))
        else $error("soft reset while busy");
    chk_soft_marks: assert property (
        softResetReq |-> ##[0:1] statusWord[4])
        else $error("soft reset not flagged in bit 4");
    chk_drive_scl_low: assert property (
        $changed(sdaOe) |-> !sclIn && sdaOut == 1'h0)
        else $error("data drive changed while clock high");
endmodule // sensor_status_chk

bind sensor_status_crc sensor_status_chk chk_u
(
    .clk(clk),
    .nrst(nrst),
    .sclIn(sclIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .trackAlertEvent(trackAlertEvent),
    .supplyFailEvent(supplyFailEvent),
    .sysIdle(sysIdle),
    .softResetReq(softResetReq),
    .statusWord(statusWord)
);

// ---- tb/testbench.sv ----
/*
 * Self-checking bench of the status block, driven through the host model.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ps
`include "sensor_status_regs.vh"

module testbench;
    reg clk = 1'h0;
    reg nrst = 1'h0;
    reg trackAlertEvent = 1'h0;
    reg supplyFailEvent = 1'h0;
    reg sysIdle = 1'h1;
    reg [15:0] rawCode = 16'h0000;
    wire sdaOut, sdaOe, softResetReq, scl, sda;
    wire [15:0] statusWord;
    integer errors = 0, num_checks = 0, pulses = 0, i, j;
    reg [31:0] seed = 46965;
    reg [15:0] w;
    reg [7:0] k, q;
    reg a;

    // =====================================================
    // clock, design and host
    always #5 clk = ~clk;
    sensor_status_crc dut_u(.clk(clk), .nrst(nrst), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .raw_temperature_code(rawCode), .trackAlertEvent(trackAlertEvent),
        .supplyFailEvent(supplyFailEvent), .sysIdle(sysIdle),
        .softResetReq(softResetReq), .statusWord(statusWord));
    host_master hm(.clk(clk), .sdaOe(sdaOe), .scl(scl), .sda(sda));
    // soft reset pulses counted to prove one per accepted command
    always @(posedge clk)
        if (softResetReq === 1'h1)
            pulses <= pulses + 1;

    // =====================================================
    // helpers
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [7:0] crc8(input [15:0] d);
        integer n;
        begin
            crc8 = 8'hFF;
            for (n = 15; n >= 0; n--)
                crc8 = {crc8[6:0], 1'h0} ^ ((crc8[7] ^ d[n]) ? 8'h31 : 8'h00);
        end
    endfunction
    // host side conversion of a raw code to whole degrees
    function integer degc(input [15:0] c);
        degc = 175 * c / 65535 - 45;
    endfunction
    function integer degf(input [15:0] c);
        degf = 315 * c / 65535 - 49;
    endfunction
    task chk(input [15:0] s, input [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // write of a command, with data word and its crc when n is 5
    task cmd(input [15:0] c, input integer n, input [15:0] d, input [7:0] r);
        reg [39:0] b;
        b = {c, d, r};
        hm.start;
        hm.xfer({`DEV_ADDR_DEFAULT, 1'h0}, 1'h1, q, a);
        chk(a, 16'h0000);
        for (i = 0; i < n; i++)
        begin
            hm.xfer(b[39 - 8 * i -: 8], 1'h1, q, a);
            chk(a, 16'h0000);
        end
        hm.stop;
        hm.w(4);
    endtask
    // read of one word and its crc, host nacks the crc
    task rd;
        hm.start;
        hm.xfer({`DEV_ADDR_DEFAULT, 1'h1}, 1'h1, q, a);
        chk(a, 16'h0000);
        hm.xfer(8'hFF, 1'h0, q, a);
        w[15:8] = q;
        hm.xfer(8'hFF, 1'h0, q, a);
        w[7:0] = q;
        hm.xfer(8'hFF, 1'h1, k, a);
        hm.stop;
        hm.w(4);
    endtask
    task pulse(input sel);
        if (sel) trackAlertEvent <= 1'h1; else supplyFailEvent <= 1'h1;
        @(posedge clk);
        trackAlertEvent <= 1'h0;
        supplyFailEvent <= 1'h0;
        hm.w(3);
    endtask

    // =====================================================
    // watchdog: a hang ends as a failed run
    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        close_out;
    end

    // =====================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        hm.w(8);
        chk(statusWord, 16'h8010);
        rd;
        chk(w, 16'h8010);
        chk(k, crc8(16'h8010));
        $display("test 1 done");
        pulse(1'h1);
        chk(statusWord, 16'h8410);
        cmd(`CMD_CLEAR_STATUS, 2, 16'h0000, 8'h00);
        chk(statusWord, 16'h0000);
        pulse(1'h0);
        chk(statusWord, 16'h0010);
        seed = xs(seed);
        cmd({8'h5A, seed[7:0]}, 2, 16'h0000, 8'h00);
        chk(statusWord & 16'h0012, 16'h0012);
        $display("test 2 done");
        // bad crc first, then good crc on the same write layout
        for (j = 1; j >= 0; j--)
        begin
            seed = xs(seed);
            cmd(`CMD_READ_STATUS, 5, seed[15:0], crc8(seed[15:0]) ^ j);
            chk(statusWord[0], j);
        end
        cmd(`CMD_CLEAR_STATUS, 2, 16'h0000, 8'h00);
        sysIdle <= 1'h0;
        cmd(`CMD_SOFT_RESET, 2, 16'h0000, 8'h00);
        chk(statusWord & 16'h0012, 16'h0002);
        sysIdle <= 1'h1;
        cmd(`CMD_SOFT_RESET, 2, 16'h0000, 8'h00);
        chk(statusWord & 16'h0012, 16'h0010);
        chk(pulses, 16'h0001);
        $display("test 3 done");
        // corner words first, then random codes
        for (j = 0; j < 8; j++)
        begin
            seed = xs(seed);
            rawCode <= (j == 0) ? 16'hBEEF : (j == 1) ? 16'hFFFF
                : (j == 2) ? 16'h0000 : seed[15:0];
            cmd(`CMD_FETCH_TEMP, 2, 16'h0000, 8'h00);
            rd;
            chk(w, rawCode);
            chk(k, crc8(rawCode));
            if (j == 0)
                chk(k, 16'h0092);
            if (j == 1)
            begin
                chk(degc(w), 16'h0082);
                chk(degf(w), 16'h010A);
            end
            if (j == 2)
            begin
                chk(degc(w), 16'hFFD3);
                chk(degf(w), 16'hFFCF);
            end
        end
        cmd(`CMD_READ_STATUS, 2, 16'h0000, 8'h00);
        rd;
        chk(w, 16'h0010);
        $display("test 4 done");
        close_out;
    end
endmodule // testbench
